// ### hw/ctcp_params.svh
// Register offsets, field positions, reset values and timing counts of the compact timer.
// Assumes inclusion by the timer module only; byte addresses on a 32-bit APB.
`ifndef CTCP_PARAMS_SVH
`define CTCP_PARAMS_SVH

`define CTCP_OFS_CTRL0 8'h00
`define CTCP_OFS_CTRL1 8'h04
`define CTCP_OFS_CNT_LO 8'h08
`define CTCP_OFS_CNT_HI 8'h0C
`define CTCP_OFS_CMPA_LO 8'h10
`define CTCP_OFS_CMPA_HI 8'h14
`define CTCP_OFS_FLAGS 8'h18

`define CTCP_CTRL0_RST 8'h00
`define CTCP_CTRL1_RST 8'h00
`define CTCP_CMPA_RST 10'h000

// Control 0 fields
`define CTCP_C0_PAUSE 7
`define CTCP_C0_CKSEL_HI 6
`define CTCP_C0_CKSEL_LO 4
`define CTCP_C0_ENABLE 3
`define CTCP_C0_PERIOD_HI 2
`define CTCP_C0_PERIOD_LO 0
// Control 1 fields
`define CTCP_C1_MODE_HI 7
`define CTCP_C1_MODE_LO 6
`define CTCP_C1_PIN_HI 5
`define CTCP_C1_PIN_LO 4
`define CTCP_C1_INIT 3
`define CTCP_C1_INVERT 2
`define CTCP_C1_SWAP 1
`define CTCP_C1_CLRSEL 0
// Flag register fields
`define CTCP_FL_A 0
`define CTCP_FL_P 1

// Counter limits, coarse comparator step and clock divider ratios
`define CTCP_CNT_MAX 10'h3FF
`define CTCP_COARSE_STEP 128
`define CTCP_FULL_PERIOD 11'h400
`define CTCP_DIV_SYS 4
`define CTCP_DIV_HIGH_A 16
`define CTCP_DIV_HIGH_B 64

`endif

// ### hw/ctcp_pkg.sv
// Types shared by the compact timer: modes, pin actions, clock choices.
// Assumes nothing beyond a SystemVerilog compiler.
package ctcp_pkg;
    typedef enum logic [1:0] {
        CTCP_MODE_COMPARE = 2'h0,
        CTCP_MODE_UNDEF = 2'h1,
        CTCP_MODE_PWM = 2'h2,
        CTCP_MODE_TIMER = 2'h3
    } ctcp_mode_t;

    typedef enum logic [1:0] {
        CTCP_PIN_KEEP = 2'h0,
        CTCP_PIN_LOW = 2'h1,
        CTCP_PIN_HIGH = 2'h2,
        CTCP_PIN_TOGGLE = 2'h3
    } ctcp_pin_action_t;

    typedef enum logic [2:0] {
        CTCP_CK_SYS_DIV4 = 3'h0,
        CTCP_CK_SYS = 3'h1,
        CTCP_CK_HIGH_DIV16 = 3'h2,
        CTCP_CK_HIGH_DIV64 = 3'h3,
        CTCP_CK_SUB_A = 3'h4,
        CTCP_CK_SUB_B = 3'h5,
        CTCP_CK_EXT_RISE = 3'h6,
        CTCP_CK_EXT_FALL = 3'h7
    } ctcp_clk_sel_t;
endpackage : ctcp_pkg

// ### hw/ctcp_timer.sv
// Compact 10-bit timer with compare-match, timer and edge-aligned PWM modes, APB registers.
// Assumes one clock, all inputs synchronous to it, tick inputs one cycle wide.
//
// What this block does
// - Counter low byte reads counter bits 7..0
// - Counter high byte: bits 9..8, rest zero
// - Compare A low byte, read/write, resets zero
// - Compare A high byte bits 9..8, rest zero
// - Mode 00, clear-select low: P-match/overflow clears, flags
// - Clear-select high: A match clears, no P flag
// - Clear-select high, compare A zero: overflow at 3FF, no flag
// - Compare mode: pin follows A match only
// - A match drives pin low, high, toggle, keep
// - Enable rising loads pin initial level
// - Timer mode counts like compare, pin unused
// - PWM ignores clear-select; period match clears counter
// - No swap: period coarse value, duty compare A
// - Swap: period compare A, duty coarse value
// - Duty at or above period gives 100%
// - PWM raises both flags on their matches
// - PWM polarity, pin action, output inversion
// - PWM keeps running while pin forced
// - Coarse value compared with counter bits 9..7
// - Enable rise zeroes counter; fall holds it
// - Pause holds counter, resume continues
// - Count clock chosen by clock select
`include "ctcp_params.svh"

module ctcp_timer
    import ctcp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic high_clk_tick_in,
    input wire logic sub_clk_tick_in,
    input wire logic external_count_clock_pin_in,
    output logic timer_pin_out,
    output logic timer_pin_oe_out,
    output logic compare_a_flag_out,
    output logic compare_p_flag_out
);

    // Coarse value to a clock count: zero stands for the full 1024 range
    function automatic logic [10:0] ctcp_coarse_len(input logic [2:0] v);
        if (v == 3'h0) begin
            return `CTCP_FULL_PERIOD;
        end
        return {1'b0, v, 7'h00};
    endfunction

    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [9:0] cmpa_q;
    logic [9:0] cnt_q;
    logic flag_a_q;
    logic flag_p_q;
    logic pin_level_q;
    logic pin_q;
    logic pin_oe_q;
    logic en_prev_q;
    logic ext_prev_q;
    logic [1:0] sys_div_q;
    logic [5:0] high_div_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    ctcp_mode_t mode;
    ctcp_pin_action_t pin_act;
    ctcp_clk_sel_t ck_sel;
    logic [2:0] coarse;
    logic enable;
    logic en_rise;
    logic tick;
    logic run;
    logic [9:0] cnt_inc;
    logic overflow;
    logic a_hit;
    logic p_hit;
    logic clr_cnt;
    logic set_a;
    logic set_p;
    logic [10:0] period_len;
    logic [10:0] duty_len;
    logic pwm_active;
    logic pwm_level;
    logic pin_d;
    logic wr_en;
    logic rd_phase;
    logic addr_ok;
    logic [31:0] rdata_d;

    assign mode = ctcp_mode_t'(ctrl1_q[`CTCP_C1_MODE_HI:`CTCP_C1_MODE_LO]);
    assign pin_act = ctcp_pin_action_t'(ctrl1_q[`CTCP_C1_PIN_HI:`CTCP_C1_PIN_LO]);
    assign ck_sel = ctcp_clk_sel_t'(ctrl0_q[`CTCP_C0_CKSEL_HI:`CTCP_C0_CKSEL_LO]);
    assign coarse = ctrl0_q[`CTCP_C0_PERIOD_HI:`CTCP_C0_PERIOD_LO];
    assign enable = ctrl0_q[`CTCP_C0_ENABLE];
    assign en_rise = enable & ~en_prev_q;

    // Count clock selection; all sources become one-cycle enables of core_clk_in
    always_comb begin
        case (ck_sel)
            CTCP_CK_SYS_DIV4: tick = (sys_div_q == 2'(`CTCP_DIV_SYS - 1));
            CTCP_CK_SYS: tick = 1'b1;
            CTCP_CK_HIGH_DIV16: tick = high_clk_tick_in &
                (high_div_q[3:0] == 4'(`CTCP_DIV_HIGH_A - 1));
            CTCP_CK_HIGH_DIV64: tick = high_clk_tick_in &
                (high_div_q == 6'(`CTCP_DIV_HIGH_B - 1));
            CTCP_CK_SUB_A, CTCP_CK_SUB_B: tick = sub_clk_tick_in;
            CTCP_CK_EXT_RISE: tick = external_count_clock_pin_in & ~ext_prev_q;
            default: tick = ~external_count_clock_pin_in & ext_prev_q;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sys_div_q <= 2'h0;
            high_div_q <= 6'h00;
            ext_prev_q <= 1'b0;
        end else begin
            sys_div_q <= sys_div_q + 2'h1;
            if (high_clk_tick_in) begin
                high_div_q <= high_div_q + 6'h01;
            end
            ext_prev_q <= external_count_clock_pin_in;
        end
    end

    // Comparators look at the value the counter is about to take
    assign run = enable & ~ctrl0_q[`CTCP_C0_PAUSE] & tick & ~en_rise;
    assign cnt_inc = cnt_q + 10'h001;
    assign overflow = (cnt_q == `CTCP_CNT_MAX);
    assign a_hit = (cnt_inc == cmpa_q);
    assign p_hit = (coarse == 3'h0) ? overflow :
        ((cnt_inc[9:7] == coarse) && (cnt_inc[6:0] == 7'h00));

    // Clear source and flag events per mode
    always_comb begin
        clr_cnt = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        if (mode == CTCP_MODE_PWM) begin
            set_a = run & a_hit;
            set_p = run & p_hit;
            if (ctrl1_q[`CTCP_C1_SWAP]) begin
                clr_cnt = run & a_hit & (cmpa_q != 10'h000);
            end else begin
                clr_cnt = run & p_hit;
            end
        end else if (ctrl1_q[`CTCP_C1_CLRSEL]) begin
            // Zero compare A would match only at wrap; let it overflow silently
            set_a = run & a_hit & (cmpa_q != 10'h000);
            clr_cnt = set_a;
        end else begin
            set_a = run & a_hit;
            set_p = run & p_hit;
            clr_cnt = set_p;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 10'h000;
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= enable;
            if (en_rise) begin
                cnt_q <= 10'h000;
            end else if (clr_cnt) begin
                cnt_q <= 10'h000;
            end else if (run) begin
                cnt_q <= cnt_inc;
            end
        end
    end

    // PWM lengths; duty at or past period saturates to always active
    assign period_len = ctrl1_q[`CTCP_C1_SWAP] ? {1'b0, cmpa_q} : ctcp_coarse_len(coarse);
    assign duty_len = ctrl1_q[`CTCP_C1_SWAP] ? ctcp_coarse_len(coarse) : {1'b0, cmpa_q};
    assign pwm_active = (duty_len >= period_len) || ({1'b0, cnt_q} < duty_len);
    assign pwm_level = pwm_active ? ctrl1_q[`CTCP_C1_INIT] : ~ctrl1_q[`CTCP_C1_INIT];

    // Compare-mode pin level, set by enable rising, moved only by A events
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_level_q <= 1'b0;
        end else if (en_rise) begin
            pin_level_q <= ctrl1_q[`CTCP_C1_INIT];
        end else if (set_a && mode == CTCP_MODE_COMPARE) begin
            case (pin_act)
                CTCP_PIN_LOW: pin_level_q <= 1'b0;
                CTCP_PIN_HIGH: pin_level_q <= 1'b1;
                CTCP_PIN_TOGGLE: pin_level_q <= ~pin_level_q;
                default: pin_level_q <= pin_level_q;
            endcase
        end
    end

    // Pin drive; PWM counting carries on whatever the pin shows
    always_comb begin
        pin_d = pin_level_q;
        if (mode == CTCP_MODE_PWM) begin
            case (pin_act)
                CTCP_PIN_LOW: pin_d = ctrl1_q[`CTCP_C1_INIT];
                CTCP_PIN_HIGH: pin_d = pwm_level;
                default: pin_d = ~ctrl1_q[`CTCP_C1_INIT];
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_q <= pin_d ^ ctrl1_q[`CTCP_C1_INVERT];
            pin_oe_q <= (mode != CTCP_MODE_TIMER);
        end
    end

    // APB: one wait state so read data leaves a flop
    assign rd_phase = psel_in & penable_in & ~pready_q;
    assign wr_en = psel_in & penable_in & pready_q & pwrite_in & ~pslverr_q;

    always_comb begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        if (paddr_in == `CTCP_OFS_CTRL0) begin
            rdata_d[7:0] = ctrl0_q;
        end else if (paddr_in == `CTCP_OFS_CTRL1) begin
            rdata_d[7:0] = ctrl1_q;
        end else if (paddr_in == `CTCP_OFS_CNT_LO) begin
            rdata_d[7:0] = cnt_q[7:0];
        end else if (paddr_in == `CTCP_OFS_CNT_HI) begin
            rdata_d[1:0] = cnt_q[9:8];
        end else if (paddr_in == `CTCP_OFS_CMPA_LO) begin
            rdata_d[7:0] = cmpa_q[7:0];
        end else if (paddr_in == `CTCP_OFS_CMPA_HI) begin
            rdata_d[1:0] = cmpa_q[9:8];
        end else if (paddr_in == `CTCP_OFS_FLAGS) begin
            rdata_d[`CTCP_FL_A] = flag_a_q;
            rdata_d[`CTCP_FL_P] = flag_p_q;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= rd_phase;
            pslverr_q <= rd_phase & ~addr_ok;
            if (rd_phase) begin
                prdata_q <= (addr_ok && !pwrite_in) ? rdata_d : 32'h0000_0000;
            end
        end
    end

    // Writes to read-only counter bytes are quietly dropped
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl0_q <= `CTCP_CTRL0_RST;
            ctrl1_q <= `CTCP_CTRL1_RST;
            cmpa_q <= `CTCP_CMPA_RST;
        end else if (wr_en) begin
            if (paddr_in == `CTCP_OFS_CTRL0) begin
                ctrl0_q <= pwdata_in[7:0];
            end else if (paddr_in == `CTCP_OFS_CTRL1) begin
                ctrl1_q <= pwdata_in[7:0];
            end else if (paddr_in == `CTCP_OFS_CMPA_LO) begin
                cmpa_q[7:0] <= pwdata_in[7:0];
            end else if (paddr_in == `CTCP_OFS_CMPA_HI) begin
                cmpa_q[9:8] <= pwdata_in[1:0];
            end
        end
    end

    // Sticky flags, write one to clear; a same-cycle event wins
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
        end else begin
            if (set_a) begin
                flag_a_q <= 1'b1;
            end else if (wr_en && paddr_in == `CTCP_OFS_FLAGS && pwdata_in[`CTCP_FL_A]) begin
                flag_a_q <= 1'b0;
            end
            if (set_p) begin
                flag_p_q <= 1'b1;
            end else if (wr_en && paddr_in == `CTCP_OFS_FLAGS && pwdata_in[`CTCP_FL_P]) begin
                flag_p_q <= 1'b0;
            end
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign timer_pin_out = pin_q;
    assign timer_pin_oe_out = pin_oe_q;
    assign compare_a_flag_out = flag_a_q;
    assign compare_p_flag_out = flag_p_q;

endmodule // ctcp_timer

// ### tb/ctcp_timer_chk.sv
// Checker for the compact timer: APB answer shape, decode and flag clearing.
// Assumes it is bound to the timer top module and sees only its ports.
module ctcp_timer_chk (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic compare_a_flag_out,
    input wire logic compare_p_flag_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_READY_IN_ACCESS: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside an access phase");
    AST_READY_PULSE: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    AST_READY_BOUND: assert property (psel_in && !penable_in |-> ##[1:3] pready_out)
        else $error("no ready after setup");
    AST_ERR_SHAPE: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error without ready or with data");
    AST_ERR_DECODE: assert property (pready_out |->
        pslverr_out == (paddr_in > 8'h18 || paddr_in[1:0] != 2'h0))
        else $error("error response does not match address");
    AST_UPPER_ZERO: assert property (pready_out && !pwrite_in |->
        prdata_out[31:8] == 24'h0)
        else $error("read data above byte not zero");
    AST_HIGH_BYTES: assert property (pready_out && !pwrite_in &&
        (paddr_in == 8'h0C || paddr_in == 8'h14) |-> prdata_out[31:2] == 30'h0)
        else $error("high byte unused bits not zero");
    AST_A_FLAG_CLEAR: assert property ($fell(compare_a_flag_out) |->
        $past(pready_out && pwrite_in && paddr_in == 8'h18 && pwdata_in[0]))
        else $error("compare A flag fell without clear");
    AST_P_FLAG_CLEAR: assert property ($fell(compare_p_flag_out) |->
        $past(pready_out && pwrite_in && paddr_in == 8'h18 && pwdata_in[1]))
        else $error("compare P flag fell without clear");
endmodule // ctcp_timer_chk

// ### tb/tb.sv
// Testbench for the compact timer: registers, clock sources, compare and PWM modes.
// Assumes the timer and its checker are compiled first; one 100 MHz clock.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in, rst_n_in, psel_in, penable_in, pwrite_in, err;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic pready_out, pslverr_out, high_clk_tick_in, sub_clk_tick_in;
    logic external_count_clock_pin_in, timer_pin_out, timer_pin_oe_out;
    logic compare_a_flag_out, compare_p_flag_out;
    logic [9:0] c, c2;
    int failures = 0;
    int comparisons = 0;
    int i, j, k, v, h, act, ini, inv, swp, rp, per;

    ctcp_timer i_ctcp_timer (.core_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .high_clk_tick_in,
        .sub_clk_tick_in, .external_count_clock_pin_in, .timer_pin_out, .timer_pin_oe_out,
        .compare_a_flag_out, .compare_p_flag_out);

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Entered just after a clock edge; leaves one idle cycle so no signal is set twice
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk_in);
            if (pready_out === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            finish_test();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic setca(input int x);
        apb(1'b1, 8'h10, 32'(x & 8'hFF));
        apb(1'b1, 8'h14, 32'((x >> 8) & 3));
    endtask

    task automatic cnt(output logic [9:0] q);
        apb(1'b0, 8'h08, 32'h0);
        q[7:0] = rd[7:0];
        apb(1'b0, 8'h0C, 32'h0);
        q[9:8] = rd[1:0];
    endtask

    // Pin high cycles over cy cycles of a PWM period pr with duty du
    function automatic int highs(int pr, int du, int a, int il, int iv, int cy);
        int on;
        on = (du >= pr) ? cy : (cy / pr) * du;
        if (a == 0) on = 0;
        if (a == 1) on = cy;
        on = il ? on : cy - on;
        return iv ? cy - on : on;
    endfunction

    // Counts expected from each clock choice: 40 core edges, 64 high ticks or the given pulses per window
    function automatic int ck_ticks(int sel, int pulses);
        case (sel)
            0: return 40 / 4;
            1: return 40;
            2: return 64 / 16;
            3: return 64 / 64;
            default: return pulses;
        endcase
    endfunction

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    initial begin
        {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {high_clk_tick_in, sub_clk_tick_in, external_count_clock_pin_in} = '0;
        void'($urandom(52278));
        repeat (16) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        for (i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK({err, rd}, {i == 7, 32'h0})
        end
        v = $urandom % 1024;
        setca(v);
        apb(1'b1, 8'h08, 32'hFF);
        cnt(c);
        `CHK(c, 10'h0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd[7:0], 8'(v))
        apb(1'b0, 8'h14, 32'h0);
        `CHK(rd, 32'(v >> 8))
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            k = 1 + $urandom % 9;
            apb(1'b1, 8'h00, 32'((i << 4) | 8));
            if (i < 4) begin
                // 37 edges plus the three of the closing write make 40 counted edges
                for (j = 0; j < ((i < 2) ? 37 : 64); j++) begin
                    high_clk_tick_in <= (i >= 2);
                    @(posedge core_clk_in);
                    high_clk_tick_in <= 1'b0;
                    if (i >= 2) @(posedge core_clk_in);
                end
            end else begin
                for (j = 0; j < k; j++) begin
                    {external_count_clock_pin_in, sub_clk_tick_in} <= 2'b11;
                    @(posedge core_clk_in);
                    {external_count_clock_pin_in, sub_clk_tick_in} <= 2'b00;
                    repeat (3) @(posedge core_clk_in);
                end
            end
            apb(1'b1, 8'h00, 32'(i << 4));
            cnt(c);
            `CHK(c, 10'(ck_ticks(i, k)))
        end
        apb(1'b1, 8'h00, 32'h18);
        repeat (20) @(posedge core_clk_in);
        apb(1'b1, 8'h00, 32'h98);
        cnt(c);
        repeat (10) @(posedge core_clk_in);
        cnt(c2);
        `CHK(c2, c)
        apb(1'b1, 8'h00, 32'h18);
        cnt(c2);
        // Two counts land between the resume write and the low byte capture
        `CHK(c2, c + 10'h002)
        $display("test clock sources done");
        for (act = 0; act < 4; act++) begin
            ini = (act == 1);
            v = 16 + $urandom % 32;
            apb(1'b1, 8'h00, 32'h10);
            apb(1'b1, 8'h18, 32'h3);
            setca(v);
            apb(1'b1, 8'h04, 32'((act << 4) | (ini << 3) | 1));
            apb(1'b1, 8'h00, 32'h18);
            // Initial level passes two flops before it shows on the pin
            repeat (2) @(posedge core_clk_in);
            `CHK({timer_pin_oe_out, timer_pin_out}, {1'b1, 1'(ini)})
            repeat (v + 10) @(posedge core_clk_in);
            // One match seen, the second still far off, so toggle has flipped once
            `CHK(timer_pin_out, 1'(act >= 2))
            `CHK({compare_a_flag_out, compare_p_flag_out}, 2'b10)
            apb(1'b0, 8'h08, 32'h0);
            `CHK(rd[7:0] < 8'(v), 1'b1)
        end
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b1, 8'h18, 32'h3);
        apb(1'b1, 8'h04, 32'hC0);
        apb(1'b1, 8'h00, 32'h18);
        repeat (1100) @(posedge core_clk_in);
        `CHK({timer_pin_oe_out, compare_a_flag_out, compare_p_flag_out}, 3'b011)
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b1, 8'h18, 32'h3);
        apb(1'b0, 8'h18, 32'h0);
        `CHK(rd, 32'h0)
        setca(0);
        apb(1'b1, 8'h04, 32'hC1);
        apb(1'b1, 8'h00, 32'h18);
        repeat (1100) @(posedge core_clk_in);
        `CHK({compare_a_flag_out, compare_p_flag_out}, 2'b00)
        $display("test compare done");
        for (i = 0; i < 8; i++) begin
            swp = $urandom % 2;
            rp = 1 + $urandom % 3;
            v = swp ? 200 + $urandom % 200 : $urandom % 420;
            if (i == 0) begin
                swp = 0;
                rp = 2;
                v = 256;
            end
            act = $urandom % 3;
            ini = $urandom % 2;
            inv = $urandom % 2;
            per = swp ? v : rp * 128;
            apb(1'b1, 8'h00, 32'h10);
            apb(1'b1, 8'h18, 32'h3);
            setca(v);
            apb(1'b1, 8'h04, 32'(8'h81 | (act << 4) | (ini << 3) | (inv << 2) | (swp << 1)));
            apb(1'b1, 8'h00, 32'(8'h18 | rp));
            repeat (8) @(posedge core_clk_in);
            h = 0;
            for (j = 0; j < 2 * per; j++) begin
                @(posedge core_clk_in);
                h += (timer_pin_out === 1'b1);
            end
            `CHK(h, highs(per, swp ? rp * 128 : v, act, ini, inv, 2 * per))
            `CHK(swp ? compare_a_flag_out : compare_p_flag_out, 1'b1)
        end
        $display("test pwm done");
        finish_test();
    end

    initial begin
        #900000;
        failures++;
        finish_test();
    end
endmodule // tb

bind ctcp_timer ctcp_timer_chk i_ctcp_timer_chk (.core_clk_in, .rst_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .compare_a_flag_out, .compare_p_flag_out);
